// ### src/smi_pme_pkg.sv
// Package: register map, field positions and reset values of the event aggregator
package smi_pme_pkg;
	// Word byte addresses on the Avalon-MM slave
	localparam logic [5:0] ADDR_MGMT_STATUS_PER = 6'h00; // Peripheral live events, no latch
	localparam logic [5:0] ADDR_MGMT_ENABLE_PER = 6'h04;
	localparam logic [5:0] ADDR_MGMT_STATUS_TWO = 6'h08;
	localparam logic [5:0] ADDR_MGMT_ENABLE_TWO = 6'h0C;
	localparam logic [5:0] ADDR_MGMT_STATUS_PIN = 6'h10;
	localparam logic [5:0] ADDR_MGMT_ENABLE_PIN = 6'h14;
	localparam logic [5:0] ADDR_WAKE_STATUS_PIN = 6'h18;
	localparam logic [5:0] ADDR_WAKE_ENABLE_PIN = 6'h1C;
	localparam logic [5:0] ADDR_PIN_POLARITY    = 6'h20;
	localparam logic [5:0] ADDR_PIN_EITHER_EDGE = 6'h24;
	localparam logic [5:0] ADDR_WAKE_STATUS_THR = 6'h28;
	localparam logic [5:0] ADDR_WAKE_ENABLE_THR = 6'h2C;
	localparam logic [5:0] ADDR_WAKE_CONTROL    = 6'h30;
	localparam logic [5:0] ADDR_PIN_CONFIG      = 6'h34;
	// Second management enable register fields
	localparam int MGMT_EN2_TO_PIN  = 7;
	localparam int MGMT_EN2_TO_SIRQ = 6;
	localparam int MGMT_EN2_TO_WAKE = 5;
	// Second management status register field (infrared, read-clears)
	localparam int MGMT_STS2_INFRARED = 0;
	// Third wake status/enable fields
	localparam int WAKE_THR_RING_ONE  = 0;
	localparam int WAKE_THR_RING_TWO  = 1;
	localparam int WAKE_THR_INFRARED  = 2;
	localparam int WAKE_THR_DEVICE    = 3;
	localparam int WAKE_THR_KEYBOARD  = 4;
	localparam int WAKE_THR_MOUSE     = 5;
	localparam int WAKE_THR_WIDTH     = 6;
	// Wake control register fields
	localparam int WAKE_CTL_GLOBAL_EN = 0;
	localparam int WAKE_CTL_SUMMARY   = 1;
	// Shared-pin configuration fields: polarity bit 0 (1 = active high), buffer bit 7 (1 = push-pull)
	localparam int PINCFG_MGMT_POL    = 0;
	localparam int PINCFG_MGMT_PP     = 7;
	localparam int PINCFG_WAKE_POL    = 8;
	localparam int PINCFG_WAKE_PP     = 15;
	localparam logic [15:0] PINCFG_RESET = 16'h0000; // Active low, open-drain
	localparam int N_PER_DEFAULT      = 8;
	localparam int N_PIN_DEFAULT      = 16;
endpackage : smi_pme_pkg

// ### src/smi_pme_event_aggregator.sv
// Management interrupt and wake event aggregator with Avalon-MM register slave
// Function
// RL1: Group interrupt is OR over sources of status AND enable.
// RL2: Interrupt pin polarity selectable, bit 7 open-drain/push-pull, default active-low open-drain.
// RL3: Group interrupt reaches its pin only with enable-two bit 7 set.
// RL4: Enable-two bit 6 routes group interrupt to serial IRQ slot two.
// RL5: Enable-two bit 5 feeds group interrupt into wake logic via device status.
// RL6: Pin/tach interrupt status sets on polarity-selected edge, rising by default.
// RL7: Either-edge mode sets pin interrupt status on both edges.
// RL8: Pin interrupt status clears on write one; write zero keeps it.
// RL9: Pin/tach events latched; latched bit ANDed with enable.
// RL10: Peripheral status cleared at source; infrared clears on reading status two.
// RL11: Peripheral live events ANDed directly with enables, no latch.
// RL12: Wake pin polarity selectable, bit 7 buffer type, default active-low open-drain.
// RL13: Wake pin inactive while global wake enable clear; enabled sources assert it otherwise.
// RL14: Summary wake status sets on enabled source transition regardless of global enable.
// RL15: Summary wake status stays set while any pending event status remains set.
// RL16: Pin wake status sets on polarity edge, both edges in either-edge mode.
// RL17: Pin wake status clears on write one; write zero keeps it.
// RL18: Wake sources: ring indicators, infrared frames, keyboard, mouse, pins, tachometer.
// RL19: Device wake status reads group-active AND enable bit 5; write one clears.
// RL20: Device wake enable and status both set assert wake pin with its polarity.
// RL21: Inverted polarity without either-edge sets status on falling edge only.
//
// Added by the designer: the address map and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module smi_pme_event_aggregator #(
	parameter int N_PER = smi_pme_pkg::N_PER_DEFAULT,
	parameter int N_PIN = smi_pme_pkg::N_PIN_DEFAULT
) (
	input  wire logic             i_sys_clk,
	input  wire logic             i_rstn,
	// Avalon-MM slave
	input  wire logic [5:0]       i_avs_address,
	input  wire logic             i_avs_read,
	input  wire logic             i_avs_write,
	input  wire logic [31:0]      i_avs_writedata,
	input  wire logic [3:0]       i_avs_byteenable,
	output logic [31:0]           o_avs_readdata,
	output logic                  o_avs_waitrequest,
	// Event inputs
	input  wire logic [N_PER-1:0] i_per_event,
	input  wire logic             i_infrared_irq_event,
	input  wire logic [N_PIN-1:0] i_pin_event,
	input  wire logic             i_ring_indicator_one,
	input  wire logic             i_ring_indicator_two,
	input  wire logic             i_infrared_frame,
	input  wire logic             i_keyboard_data,
	input  wire logic             i_mouse_data,
	// Outputs
	output logic                  o_mgmt_irq_pin_out,
	output logic                  o_mgmt_irq_pin_oe,
	output logic                  o_sirq_slot_two,
	output logic                  o_wake_event_pin_out,
	output logic                  o_wake_event_pin_oe
);
	import smi_pme_pkg::*;

	// Pin events (GPIOs and tachometer) and ring/data lines are asynchronous
	logic [N_PIN-1:0] pin_meta, pin_sync, pin_prev;
	logic [4:0]       misc_meta, misc_sync, misc_prev;
	logic [N_PER-1:0] per_meta, per_sync;
	logic             ir_meta, ir_sync;

	// Pin and tachometer lines, third stage kept for edge detection
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pin_meta <= '0;
			pin_sync <= '0;
			pin_prev <= '0;
		end else begin
			pin_meta <= i_pin_event;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	// Ring, frame, keyboard and mouse; reset low matches their idle level
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			misc_meta <= '0;
			misc_sync <= '0;
			misc_prev <= '0;
		end else begin
			misc_meta <= {i_mouse_data, i_keyboard_data, i_infrared_frame, i_ring_indicator_two,
				i_ring_indicator_one};
			misc_sync <= misc_meta;
			misc_prev <= misc_sync;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			per_meta <= '0;
			per_sync <= '0;
		end else begin
			per_meta <= i_per_event;
			per_sync <= per_meta;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ir_meta <= 1'b0;
			ir_sync <= 1'b0;
		end else begin
			ir_meta <= i_infrared_irq_event;
			ir_sync <= ir_meta;
		end
	end

	// Registers
	logic [N_PER-1:0] mgmt_enable_per;
	logic [7:0]       mgmt_irq_enable_two;
	logic             infrared_status;
	logic [N_PIN-1:0] mgmt_status_pin, mgmt_enable_pin;
	logic [N_PIN-1:0] wake_status_pin, wake_enable_pin;
	logic [N_PIN-1:0] pin_polarity, either_edge_trigger;
	logic [WAKE_THR_WIDTH-1:0] wake_status_three, wake_enable_three;
	logic             wake_global_enable;
	logic [15:0]      pin_config;

	// Writes take no wait state; reads take one so read data comes from a flop
	logic wr_ack, rd_capture, rd_pend;
	assign wr_ack            = i_avs_write;
	assign rd_capture        = i_avs_read & ~rd_pend;
	assign o_avs_waitrequest = rd_capture;

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rd_pend <= 1'b0;
		end else begin
			rd_pend <= rd_capture;
		end
	end

	function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction : merge_be

	// Write-one-clear mask for the addressed word
	function automatic logic [31:0] w1c_mask(input logic [5:0] reg_addr);
		logic [31:0] m;
		m = '0;
		if (wr_ack && i_avs_address == reg_addr) begin
			m = merge_be(32'h0000_0000, i_avs_writedata, i_avs_byteenable);
		end
		return m;
	endfunction : w1c_mask

	// Active edge selection, shared by management and wake paths
	function automatic logic [N_PIN-1:0] pin_edges(input logic [N_PIN-1:0] cur,
		input logic [N_PIN-1:0] prv, input logic [N_PIN-1:0] pol, input logic [N_PIN-1:0] eet);
		logic [N_PIN-1:0] rise, fall;
		rise = cur & ~prv;
		fall = ~cur & prv;
		return (eet & (rise | fall)) | (~eet & ~pol & rise) | (~eet & pol & fall); // [RL6] [RL7] [RL16] [RL21]
	endfunction : pin_edges

	logic [N_PIN-1:0] pin_hit;
	assign pin_hit = pin_edges(pin_sync, pin_prev, pin_polarity, either_edge_trigger);

	// Write strobe for one register word
	function automatic logic wr_hit(input logic [5:0] reg_addr);
		return wr_ack && i_avs_address == reg_addr;
	endfunction : wr_hit

	// Configuration registers, one block each
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			mgmt_enable_per <= '0;
		end else if (wr_hit(ADDR_MGMT_ENABLE_PER)) begin
			mgmt_enable_per <= N_PER'(merge_be(32'(mgmt_enable_per), i_avs_writedata, i_avs_byteenable));
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			mgmt_irq_enable_two <= 8'h00;
		end else if (wr_hit(ADDR_MGMT_ENABLE_TWO)) begin
			mgmt_irq_enable_two <= 8'(merge_be(32'(mgmt_irq_enable_two), i_avs_writedata, i_avs_byteenable));
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			mgmt_enable_pin <= '0;
		end else if (wr_hit(ADDR_MGMT_ENABLE_PIN)) begin
			mgmt_enable_pin <= N_PIN'(merge_be(32'(mgmt_enable_pin), i_avs_writedata, i_avs_byteenable));
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wake_enable_pin <= '0;
		end else if (wr_hit(ADDR_WAKE_ENABLE_PIN)) begin
			wake_enable_pin <= N_PIN'(merge_be(32'(wake_enable_pin), i_avs_writedata, i_avs_byteenable));
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pin_polarity <= '0;
		end else if (wr_hit(ADDR_PIN_POLARITY)) begin
			pin_polarity <= N_PIN'(merge_be(32'(pin_polarity), i_avs_writedata, i_avs_byteenable));
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			either_edge_trigger <= '0;
		end else if (wr_hit(ADDR_PIN_EITHER_EDGE)) begin
			either_edge_trigger <= N_PIN'(merge_be(32'(either_edge_trigger), i_avs_writedata,
				i_avs_byteenable));
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wake_enable_three <= '0;
		end else if (wr_hit(ADDR_WAKE_ENABLE_THR)) begin
			wake_enable_three <= WAKE_THR_WIDTH'(merge_be(32'(wake_enable_three), i_avs_writedata,
				i_avs_byteenable));
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wake_global_enable <= 1'b0;
		end else if (wr_hit(ADDR_WAKE_CONTROL) && i_avs_byteenable[0]) begin
			wake_global_enable <= i_avs_writedata[WAKE_CTL_GLOBAL_EN];
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pin_config <= PINCFG_RESET;
		end else if (wr_hit(ADDR_PIN_CONFIG)) begin
			pin_config <= 16'(merge_be(32'(pin_config), i_avs_writedata, i_avs_byteenable));
		end
	end

	// Pin management status: set beats write-one clear
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			mgmt_status_pin <= '0;
		end else begin
			mgmt_status_pin <= (mgmt_status_pin & ~N_PIN'(w1c_mask(ADDR_MGMT_STATUS_PIN))) | pin_hit; // [RL8] [RL9]
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wake_status_pin <= '0;
		end else begin
			wake_status_pin <= (wake_status_pin & ~N_PIN'(w1c_mask(ADDR_WAKE_STATUS_PIN))) | pin_hit; // [RL16] [RL17]
		end
	end

	// Infrared latch clears on a read of status two; a new event in that cycle wins
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			infrared_status <= 1'b0;
		end else if (ir_sync) begin
			infrared_status <= 1'b1;
		end else if (rd_capture && i_avs_address == ADDR_MGMT_STATUS_TWO) begin
			infrared_status <= 1'b0; // [RL10]
		end
	end

	// Group interrupt, active high internally
	logic group_mgmt_irq;
	assign group_mgmt_irq = (|(per_sync & mgmt_enable_per))   // [RL11]
		| (|(mgmt_status_pin & mgmt_enable_pin))              // [RL9]
		| (infrared_status & mgmt_irq_enable_two[MGMT_STS2_INFRARED]); // [RL1]

	// Wake status three: rising edges of ring, infrared, keyboard, mouse, plus device level
	logic [4:0] misc_hit;
	logic       device_irq_wake_status;
	assign misc_hit = misc_sync & ~misc_prev; // [RL18]
	assign device_irq_wake_status = wake_status_three[WAKE_THR_DEVICE];

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wake_status_three <= '0;
		end else begin
			wake_status_three <= (wake_status_three & ~WAKE_THR_WIDTH'(w1c_mask(ADDR_WAKE_STATUS_THR)))
				| {misc_hit[4:3], group_mgmt_irq & mgmt_irq_enable_two[MGMT_EN2_TO_WAKE], // [RL5] [RL19]
				misc_hit[2:0]};
		end
	end

	// Summary: pending enabled status, independent of global enable
	logic wake_pending, wake_summary_status;
	assign wake_pending = (|(wake_status_pin & wake_enable_pin)) | (|(wake_status_three & wake_enable_three));
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wake_summary_status <= 1'b0;
		end else if (wake_pending) begin
			wake_summary_status <= 1'b1; // [RL14] [RL15]
		end else if (wr_ack && i_avs_address == ADDR_WAKE_CONTROL && i_avs_byteenable[0]
			&& i_avs_writedata[WAKE_CTL_SUMMARY]) begin
			wake_summary_status <= 1'b0;
		end
	end

	logic wake_active, mgmt_pin_active;
	assign wake_active = wake_global_enable & wake_pending; // [RL13] [RL20]
	assign mgmt_pin_active = group_mgmt_irq & mgmt_irq_enable_two[MGMT_EN2_TO_PIN]; // [RL3]

	// Pin levels after polarity: polarity bit set means active high
	logic mgmt_level, wake_level;
	assign mgmt_level = mgmt_pin_active ~^ pin_config[PINCFG_MGMT_POL];
	assign wake_level = wake_active ~^ pin_config[PINCFG_WAKE_POL];

	// Open-drain drives only the low level; only push-pull mode drives a shared line high
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_mgmt_irq_pin_out <= 1'b0;
			o_mgmt_irq_pin_oe  <= 1'b0;
		end else begin
			o_mgmt_irq_pin_out <= mgmt_level; // [RL2]
			o_mgmt_irq_pin_oe  <= pin_config[PINCFG_MGMT_PP] | ~mgmt_level; // [RL2]
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_wake_event_pin_out <= 1'b0;
			o_wake_event_pin_oe  <= 1'b0;
		end else begin
			o_wake_event_pin_out <= wake_level; // [RL12]
			o_wake_event_pin_oe  <= pin_config[PINCFG_WAKE_PP] | ~wake_level; // [RL12]
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_sirq_slot_two <= 1'b0;
		end else begin
			o_sirq_slot_two <= group_mgmt_irq & mgmt_irq_enable_two[MGMT_EN2_TO_SIRQ]; // [RL4]
		end
	end

	// Read value, taken into the data flop in the wait cycle
	logic [31:0] read_mux;
	always_comb begin
		read_mux = 32'h0000_0000;
		unique case (i_avs_address)
			ADDR_MGMT_STATUS_PER: read_mux = 32'(per_sync);
			ADDR_MGMT_ENABLE_PER: read_mux = 32'(mgmt_enable_per);
			ADDR_MGMT_STATUS_TWO: read_mux = 32'(infrared_status);
			ADDR_MGMT_ENABLE_TWO: read_mux = 32'(mgmt_irq_enable_two);
			ADDR_MGMT_STATUS_PIN: read_mux = 32'(mgmt_status_pin);
			ADDR_MGMT_ENABLE_PIN: read_mux = 32'(mgmt_enable_pin);
			ADDR_WAKE_STATUS_PIN: read_mux = 32'(wake_status_pin);
			ADDR_WAKE_ENABLE_PIN: read_mux = 32'(wake_enable_pin);
			ADDR_PIN_POLARITY:    read_mux = 32'(pin_polarity);
			ADDR_PIN_EITHER_EDGE: read_mux = 32'(either_edge_trigger);
			ADDR_WAKE_STATUS_THR: read_mux = 32'(wake_status_three);
			ADDR_WAKE_ENABLE_THR: read_mux = 32'(wake_enable_three);
			ADDR_WAKE_CONTROL:    read_mux = 32'({wake_summary_status, wake_global_enable});
			ADDR_PIN_CONFIG:      read_mux = 32'(pin_config);
			default:              read_mux = 32'h0000_0000;
		endcase
	end

	// Captured on the same edge that clears the infrared latch, so no event is lost
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_avs_readdata <= 32'h0000_0000;
		end else if (rd_capture) begin
			o_avs_readdata <= read_mux;
		end
	end
endmodule : smi_pme_event_aggregator
`default_nettype wire

// ### bench/smi_pme_asserts.sv
// Checker for pin gating, buffer type and live-event paths
`timescale 1ns/1ns
`default_nettype none
module smi_pme_asserts import smi_pme_pkg::*; #(
	parameter int N_PER = 8
) (
	input wire logic             i_sys_clk,
	input wire logic             i_rstn,
	input wire logic [5:0]       i_avs_address,
	input wire logic             i_avs_read,
	input wire logic             i_avs_write,
	input wire logic [31:0]      i_avs_writedata,
	input wire logic [3:0]       i_avs_byteenable,
	input wire logic             o_avs_waitrequest,
	input wire logic [N_PER-1:0] i_per_event,
	input wire logic             o_mgmt_irq_pin_out,
	input wire logic             o_mgmt_irq_pin_oe,
	input wire logic             o_sirq_slot_two,
	input wire logic             o_wake_event_pin_out,
	input wire logic             o_wake_event_pin_oe
);
	logic [7:0]       en2;
	logic [N_PER-1:0] pen;
	logic [15:0]      cfg;
	logic             gen;
	// Shadows only full-word writes; partial lanes are not tracked
	wire logic full_wr = i_avs_write && i_avs_byteenable == 4'hF;
	wire logic per_hit = |(i_per_event & pen);
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			en2 <= '0;
			pen <= '0;
			cfg <= PINCFG_RESET;
			gen <= 1'b0;
		end else if (full_wr) begin
			if (i_avs_address == ADDR_MGMT_ENABLE_TWO) en2 <= i_avs_writedata[7:0];
			if (i_avs_address == ADDR_MGMT_ENABLE_PER) pen <= i_avs_writedata[N_PER-1:0];
			if (i_avs_address == ADDR_PIN_CONFIG) cfg <= i_avs_writedata[15:0];
			if (i_avs_address == ADDR_WAKE_CONTROL) gen <= i_avs_writedata[WAKE_CTL_GLOBAL_EN];
		end
	end
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);
	no_wait_a: assert property (!i_avs_read |-> !o_avs_waitrequest) else $error("waitrequest raised");
	read_wait_a: assert property (o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("read held off for more than one cycle");
	sirq_gate_a: assert property (o_sirq_slot_two |-> $past(en2[6]))
		else $error("serial slot raised without its enable");
	sirq_live_a: assert property ((en2[6] && per_hit) [*6] |-> o_sirq_slot_two)
		else $error("live event missing on serial slot");
	irq_gate_a: assert property ($past(i_rstn) && $past(cfg) == 16'h0000 && !$past(en2[7])
		|-> o_mgmt_irq_pin_out && !o_mgmt_irq_pin_oe) else $error("interrupt pin not released");
	irq_live_a: assert property ((en2[7] && per_hit && cfg == 16'h0000) [*6]
		|-> o_mgmt_irq_pin_oe && !o_mgmt_irq_pin_out) else $error("interrupt pin not asserted");
	irq_od_a: assert property (!$past(cfg[7]) |-> !(o_mgmt_irq_pin_oe && o_mgmt_irq_pin_out))
		else $error("open-drain interrupt pin drove high");
	wake_od_a: assert property (!$past(cfg[15]) |-> !(o_wake_event_pin_oe && o_wake_event_pin_out))
		else $error("open-drain wake pin drove high");
	wake_gate_a: assert property ($past(i_rstn) && !$past(gen) && $past(cfg[8]) == $past(cfg[15])
		|-> o_wake_event_pin_out == !$past(cfg[8]) && o_wake_event_pin_oe == $past(cfg[15]))
		else $error("wake pin active while globally disabled");
endmodule : smi_pme_asserts
bind smi_pme_event_aggregator smi_pme_asserts #(.N_PER(N_PER)) chk (.i_sys_clk, .i_rstn, .i_avs_address, .i_avs_read,
	.i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_waitrequest, .i_per_event, .o_mgmt_irq_pin_out,
	.o_mgmt_irq_pin_oe, .o_sirq_slot_two, .o_wake_event_pin_out, .o_wake_event_pin_oe);
`default_nettype wire

// ### bench/host_pm_model.sv
// Host board side of the two shared pins
`timescale 1ns/1ns
`default_nettype none
module host_pm_model (
	input  wire logic i_irq_out,
	input  wire logic i_irq_oe,
	input  wire logic i_wake_out,
	input  wire logic i_wake_oe,
	output logic      o_irq_wire,
	output logic      o_wake_wire
);
	// Released pins sit at the board pull-up, never at a stale value
	assign o_irq_wire  = i_irq_oe ? i_irq_out : 1'b1;
	assign o_wake_wire = i_wake_oe ? i_wake_out : 1'b1;
endmodule : host_pm_model
`default_nettype wire

// ### bench/smi_pme_event_aggregator_test.sv
// Bench: register traffic and event stimulus with queued expectations
`timescale 1ns/1ns
`default_nettype none
module smi_pme_event_aggregator_test;
	import smi_pme_pkg::*;
	logic        clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, look = 1'b0, ir = 1'b0;
	logic [5:0]  addr = '0;
	logic [31:0] wdata = '0, lf = 32'h5B165586, rdata, got;
	logic [7:0]  per = '0;
	logic [15:0] pin = '0;
	logic [4:0]  src = '0;
	logic [3:0]  be = 4'hF;
	logic [39:0] acc = 40'h3F1F0F0B09;
	logic        wreq, irq_o, irq_e, sirq, wk_o, wk_e, irq_w, wk_w;
	int          err_count = 0, check_count = 0;
	logic [31:0] q[$];
	always #2 clk = ~clk;
	smi_pme_event_aggregator uut (.i_sys_clk(clk), .i_rstn(rstn), .i_avs_address(addr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata),
		.o_avs_waitrequest(wreq), .i_per_event(per), .i_infrared_irq_event(ir), .i_pin_event(pin),
		.i_ring_indicator_one(src[0]), .i_ring_indicator_two(src[1]), .i_infrared_frame(src[2]),
		.i_keyboard_data(src[3]), .i_mouse_data(src[4]), .o_mgmt_irq_pin_out(irq_o),
		.o_mgmt_irq_pin_oe(irq_e), .o_sirq_slot_two(sirq), .o_wake_event_pin_out(wk_o), .o_wake_event_pin_oe(wk_e));
	host_pm_model host (.i_irq_out(irq_o), .i_irq_oe(irq_e), .i_wake_out(wk_o), .i_wake_oe(wk_e),
		.o_irq_wire(irq_w), .o_wake_wire(wk_w));
	always @(posedge clk) begin
		if ((rd && wreq === 1'b0) || look) begin
			got = look ? {29'h0, irq_w, wk_w, sirq} : rdata;
			check_count++;
			if (q.size() == 0 || got !== q[0]) begin
				err_count++;
				$display("ERROR t=%0t got %h exp %h", $time, got, q.size() ? q[0] : 32'h0);
			end
			if (q.size() > 0) void'(q.pop_front());
		end
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		rd <= !w;
		wr <= w;
		do @(posedge clk); while (wreq !== 1'b0);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
		q.push_back(e);
		bus(a, 1'b0, 32'h0);
	endtask : rd_chk
	// Two sync flops, edge detect, status, then the pin register
	task automatic pins(input logic [2:0] e);
		repeat (6) @(posedge clk);
		q.push_back({29'h0, e});
		look <= 1'b1;
		@(posedge clk);
		look <= 1'b0;
	endtask : pins
	task automatic finish_test;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : finish_test
	initial begin
		repeat (5000) @(posedge clk);
		err_count++;
		finish_test();
	end
	initial begin
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		rd_chk(ADDR_PIN_CONFIG, 32'h0);
		rd_chk(6'h3C, 32'h0);
		be <= 4'h2;
		bus(ADDR_MGMT_ENABLE_TWO, 1'b1, 32'hFF);
		be <= 4'hF;
		rd_chk(ADDR_MGMT_ENABLE_TWO, 32'h0);
		pins(3'b110);
		lf = lfsr(lf);
		per <= lf[7:0] | 8'h01;
		bus(ADDR_MGMT_ENABLE_PER, 1'b1, {24'h0, lf[15:8] | 8'h01});
		bus(ADDR_MGMT_ENABLE_TWO, 1'b1, 32'hC0);
		pins(3'b011);
		bus(ADDR_MGMT_STATUS_PER, 1'b1, 32'hFF);
		rd_chk(ADDR_MGMT_STATUS_PER, {24'h0, lf[7:0] | 8'h01});
		bus(ADDR_MGMT_ENABLE_TWO, 1'b1, 32'h0);
		pins(3'b110);
		per <= 8'h00;
		bus(ADDR_MGMT_ENABLE_TWO, 1'b1, 32'hC0);
		pins(3'b110);
		pin <= 16'h0002;
		bus(ADDR_PIN_POLARITY, 1'b1, 32'h2);
		bus(ADDR_PIN_EITHER_EDGE, 1'b1, 32'h4);
		bus(ADDR_MGMT_STATUS_PIN, 1'b1, 32'hFFFF);
		bus(ADDR_WAKE_STATUS_PIN, 1'b1, 32'hFFFF);
		pin <= 16'h0007;
		pins(3'b110);
		rd_chk(ADDR_MGMT_STATUS_PIN, 32'h5);
		pin <= 16'h0000;
		pins(3'b110);
		rd_chk(ADDR_MGMT_STATUS_PIN, 32'h7);
		rd_chk(ADDR_WAKE_STATUS_PIN, 32'h7);
		bus(ADDR_MGMT_STATUS_PIN, 1'b1, 32'h1);
		rd_chk(ADDR_MGMT_STATUS_PIN, 32'h6);
		bus(ADDR_MGMT_ENABLE_PIN, 1'b1, 32'h2);
		pins(3'b011);
		bus(ADDR_MGMT_STATUS_PIN, 1'b1, 32'h6);
		bus(ADDR_WAKE_STATUS_PIN, 1'b1, 32'h7);
		rd_chk(ADDR_WAKE_STATUS_PIN, 32'h0);
		bus(ADDR_WAKE_ENABLE_PIN, 1'b1, 32'h1);
		pin <= 16'h0001;
		pins(3'b110);
		rd_chk(ADDR_WAKE_CONTROL, 32'h2);
		bus(ADDR_WAKE_CONTROL, 1'b1, 32'h3);
		pins(3'b100);
		rd_chk(ADDR_WAKE_CONTROL, 32'h3);
		bus(ADDR_WAKE_STATUS_PIN, 1'b1, 32'hFFFF);
		bus(ADDR_WAKE_CONTROL, 1'b1, 32'h3);
		rd_chk(ADDR_WAKE_CONTROL, 32'h1);
		per <= 8'h01;
		bus(ADDR_MGMT_ENABLE_PER, 1'b1, 32'h1);
		bus(ADDR_MGMT_ENABLE_TWO, 1'b1, 32'h20);
		pins(3'b110);
		rd_chk(ADDR_WAKE_STATUS_THR, 32'h8);
		bus(ADDR_WAKE_ENABLE_THR, 1'b1, 32'h8);
		pins(3'b100);
		for (int k = 0; k < 5; k++) begin
			src[k] <= 1'b1;
			pins(3'b100);
			rd_chk(ADDR_WAKE_STATUS_THR, {24'h0, acc[k*8 +: 8]});
		end
		ir <= 1'b1;
		pins(3'b100);
		ir <= 1'b0;
		pins(3'b100);
		rd_chk(ADDR_MGMT_STATUS_TWO, 32'h1);
		rd_chk(ADDR_MGMT_STATUS_TWO, 32'h0);
		bus(ADDR_PIN_CONFIG, 1'b1, 32'h8181);
		bus(ADDR_MGMT_ENABLE_TWO, 1'b1, 32'hA0);
		pins(3'b110);
		bus(ADDR_MGMT_ENABLE_TWO, 1'b1, 32'h20);
		bus(ADDR_WAKE_CONTROL, 1'b1, 32'h0);
		pins(3'b000);
		finish_test();
	end
endmodule : smi_pme_event_aggregator_test
`default_nettype wire
